/* rtl/qep_pkg.sv */
// Shared constants for the encoder watchdog, unit timer and interrupt block
package qep_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [7:0] A_DEC_CTL  = 8'h00;
	localparam logic [7:0] A_CTL      = 8'h04;
	localparam logic [7:0] A_WD_PRD   = 8'h08;
	localparam logic [7:0] A_WD_CNT   = 8'h0C;
	localparam logic [7:0] A_UNIT_PRD = 8'h10;
	localparam logic [7:0] A_UNIT_CNT = 8'h14;
	localparam logic [7:0] A_IRQ_EN   = 8'h18;
	localparam logic [7:0] A_IRQ_FLG  = 8'h1C;
	localparam logic [7:0] A_IRQ_CLR  = 8'h20;
	localparam logic [7:0] A_IRQ_FRC  = 8'h24;
	localparam logic [7:0] A_POS_CNT  = 8'h28;
	localparam logic [7:0] A_POS_LAT  = 8'h2C;
	localparam logic [7:0] A_CTMR_LAT = 8'h30;
	localparam logic [7:0] A_CPRD_LAT = 8'h34;
	// Decoder control fields
	localparam int SRC_HI     = 15;
	localparam int SRC_LO     = 14;
	localparam int SYNC_EN_B  = 13;
	localparam int SYNC_PIN_B = 12;
	localparam int RATE_B     = 11;
	localparam int SWAP_B     = 10;
	localparam int GATE_B     = 9;
	localparam int INV_HI   = 8;
	localparam int INV_LO   = 5;
	localparam logic [15:0] DEC_CTL_RST  = 16'h0000;
	localparam logic [15:0] DEC_CTL_MASK = 16'hFFE0;
	// Own control register bits
	localparam int WD_EN_B   = 0;
	localparam int UNIT_EN_B = 1;
	localparam int CLM_B     = 2;
	localparam logic [2:0] CTL_RST = 3'h0;
	// Interrupt flag bit positions
	localparam int IRQ_W   = 12;
	localparam int F_INT   = 0;
	localparam int F_PHASE  = 2;
	localparam int F_DIRCHG = 3;
	localparam int F_WDOG   = 4;
	localparam int F_UNIT   = 11;
	localparam logic [11:0] EVT_MASK = 12'hFFE;
	localparam logic [11:0] EXT_MASK = 12'h7E2;
	// Watchdog tick divider
	localparam int WD_DIV   = 64;
	localparam int WD_PRE_W = 6;
	typedef enum logic [1:0] {
		SRC_QUAD   = 2'b00,
		SRC_DIRCNT = 2'b01,
		SRC_UP     = 2'b10,
		SRC_DOWN   = 2'b11
	} count_src_e;
endpackage

/* rtl/dec_if.sv */
// Configuration and results between core and input decoder
`timescale 1ns/1ps
`default_nettype none
interface dec_if;
	logic [1:0] src;
	logic       rate;
	logic       swap;
	logic       gate;
	logic [3:0] inv;
	logic       cnt_pulse;
	logic       cnt_dir;
	logic       idx;
	logic       stb;
	logic       phase_err;
	logic       dir_chg;
	modport dec (input src, rate, swap, gate, inv,
		output cnt_pulse, cnt_dir, idx, stb, phase_err, dir_chg);
	modport core (output src, rate, swap, gate, inv,
		input cnt_pulse, cnt_dir, idx, stb, phase_err, dir_chg);
endinterface
`default_nettype wire

/* rtl/qep_decoder.sv */
// Pin synchronisers, polarity, swap, gating and quadrature decode
`timescale 1ns/1ps
`default_nettype none
module qep_decoder import qep_pkg::*; (
	input  wire logic pclk,       // System clock
	input  wire logic presetn,    // Async reset, active low
	dec_if.dec        d,          // Core side
	input  wire logic phase_a_in, // Encoder phase A pin
	input  wire logic phase_b_in, // Encoder phase B pin
	input  wire logic index_in,   // Index pin
	input  wire logic strobe_in   // Strobe pin
);
	// Bit order {a, b, index, strobe}
	logic [3:0] s1_q, s2_q, s3_q, f_q, pol;
	logic       a, b, a_q, b_q, ea, eb, xev, ev, dir;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			f_q  <= '0;
		end else begin
			s1_q <= {phase_a_in, phase_b_in, index_in, strobe_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < 4; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					f_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign pol = f_q ^ d.inv;
	assign a = d.swap ? pol[2] : pol[3];
	assign b = d.swap ? pol[3] : pol[2];
	assign ea = a ^ a_q;
	assign eb = b ^ b_q;
	assign xev = d.rate ? (a & ~a_q) : ea;

	always_comb begin
		ev  = 1'b0;
		dir = d.cnt_dir;
		unique case (count_src_e'(d.src))
			SRC_QUAD: begin
				ev  = ea ^ eb;
				dir = b_q ^ a;
			end
			SRC_DIRCNT: begin
				ev  = xev;
				dir = b;
			end
			SRC_UP: begin
				ev  = xev;
				dir = 1'b1;
			end
			SRC_DOWN: begin
				ev  = xev;
				dir = 1'b0;
			end
		endcase
	end

	// Polarity or swap changes can fake one edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_q         <= 1'b0;
			b_q         <= 1'b0;
			d.cnt_pulse <= 1'b0;
			d.cnt_dir   <= 1'b0;
			d.dir_chg   <= 1'b0;
			d.phase_err <= 1'b0;
			d.idx       <= 1'b0;
			d.stb       <= 1'b0;
		end else begin
			a_q         <= a;
			b_q         <= b;
			d.cnt_pulse <= ev;
			d.dir_chg   <= ev && (dir != d.cnt_dir);
			d.phase_err <= (d.src == SRC_QUAD) && ea && eb;
			if (ev) begin
				d.cnt_dir <= dir;
			end
			d.idx <= d.gate ? (pol[1] & pol[0]) : pol[1];
			d.stb <= pol[0];
		end
	end

	property p_gate;
		@(posedge pclk) disable iff (!presetn)
		(d.gate && !pol[0]) |=> !d.idx;
	endproperty
	a_gate: assert property (p_gate)
		else $error("index passed while gated off");
endmodule
`default_nettype wire

/* rtl/qep_timers.sv */
// Encoder watchdog and unit time base
`timescale 1ns/1ps
`default_nettype none
module qep_timers import qep_pkg::*; #(
	parameter int WD_W = 16,
	parameter int UT_W = 32
) (
	input  wire logic            pclk,        // System clock
	input  wire logic            presetn,     // Async reset, active low
	input  wire logic            wd_en,       // Watchdog enable
	input  wire logic            unit_en,     // Unit timer enable
	input  wire logic            cnt_pulse,   // Quadrature count pulse
	input  wire logic [WD_W-1:0] wd_period,   // Watchdog period
	input  wire logic [UT_W-1:0] unit_period, // Unit period
	output logic      [WD_W-1:0] wd_count,    // Watchdog count
	output logic      [UT_W-1:0] unit_count,  // Unit timer count
	output logic                 wd_timeout,  // Watchdog time-out pulse
	output logic                 unit_timeout // Unit time-out pulse
);
	logic [WD_PRE_W-1:0] pre_q;
	logic                tick;

	assign tick = wd_en && (pre_q == WD_PRE_W'(WD_DIV - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= '0;
		end else if (wd_en) begin
			pre_q <= pre_q + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_count   <= '0;
			wd_timeout <= 1'b0;
		end else begin
			wd_timeout <= 1'b0;
			if (cnt_pulse) begin
				wd_count <= '0;
			end else if (tick && wd_count == wd_period) begin
				wd_count   <= '0;
				wd_timeout <= 1'b1;
			end else if (tick) begin
				wd_count <= wd_count + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_count   <= '0;
			unit_timeout <= 1'b0;
		end else begin
			unit_timeout <= 1'b0;
			if (unit_en) begin
				if (unit_count == unit_period) begin
					unit_count   <= '0;
					unit_timeout <= 1'b1;
				end else begin
					unit_count <= unit_count + 1'b1;
				end
			end
		end
	end

	property p_wd_tick;
		@(posedge pclk) disable iff (!presetn)
		(!cnt_pulse && !tick) |=> $stable(wd_count);
	endproperty
	a_wd_tick: assert property (p_wd_tick)
		else $error("watchdog moved without tick");

	property p_wd_clr;
		@(posedge pclk) disable iff (!presetn)
		cnt_pulse |=> (wd_count == '0) && !wd_timeout;
	endproperty
	a_wd_clr: assert property (p_wd_clr)
		else $error("watchdog not cleared by quad_clock");

	property p_wd_to;
		@(posedge pclk) disable iff (!presetn)
		(tick && !cnt_pulse && wd_count == wd_period) |=> wd_timeout;
	endproperty
	a_wd_to: assert property (p_wd_to)
		else $error("watchdog time-out missing");

	property p_unit_cnt;
		@(posedge pclk) disable iff (!presetn)
		(unit_en && unit_count != unit_period)
			|=> unit_count == $past(unit_count) + 1'b1;
	endproperty
	a_unit_cnt: assert property (p_unit_cnt)
		else $error("unit timer did not advance");

	property p_unit_to;
		@(posedge pclk) disable iff (!presetn)
		(unit_en && unit_count == unit_period)
			|=> unit_timeout && unit_count == '0;
	endproperty
	a_unit_to: assert property (p_unit_to)
		else $error("unit time-out missing");
endmodule
`default_nettype wire

/* rtl/qep_core.sv */
// Encoder interface core: registers, interrupts, latching, sync output
`timescale 1ns/1ps
`default_nettype none
module qep_core import qep_pkg::*; #(
	parameter int WD_W = 16,
	parameter int UT_W = 32,
	parameter int POS_W = 32,
	parameter int CAP_W = 16
) (
	input  wire logic              pclk,           // System clock
	input  wire logic              presetn,        // Async reset
	input  wire logic [ADDR_W-1:0] paddr,          // APB address
	input  wire logic              psel,           // APB select
	input  wire logic              penable,        // APB enable
	input  wire logic              pwrite,         // APB direction
	input  wire logic [DATA_W-1:0] pwdata,         // APB write data
	output logic      [DATA_W-1:0] prdata,         // APB read data
	output logic                   pready,         // APB ready
	output logic                   pslverr,        // APB error
	input  wire logic              phase_a_in,     // Phase A pin
	input  wire logic              phase_b_in,     // Phase B pin
	input  wire logic              index_in,       // Index pin in
	input  wire logic              strobe_in,      // Strobe pin in
	input  wire logic [POS_W-1:0]  position_count, // Position counter
	input  wire logic [CAP_W-1:0]  capture_timer,  // Capture timer
	input  wire logic [CAP_W-1:0]  capture_period, // Capture period
	input  wire logic [IRQ_W-1:0]  ext_events,     // Other unit events
	input  wire logic              sync_pulse,     // Compare sync pulse
	output logic                   quad_clock,     // Count pulse
	output logic                   quad_direction, // Count direction
	output logic                   index_level,    // Qualified index
	output logic                   strobe_level,   // Qualified strobe
	output logic                   index_out,      // Index pin drive
	output logic                   index_oe,       // Index pin enable
	output logic                   strobe_out,     // Strobe pin drive
	output logic                   strobe_oe,      // Strobe pin enable
	output logic                   irq             // Interrupt pulse
);
	dec_if dif ();

	logic [15:0]      dec_ctl_q;
	logic [2:0]       ctl_q;
	logic [WD_W-1:0]  wd_period_reg;
	logic [WD_W-1:0]  wd_count_reg;
	logic [UT_W-1:0]  unit_period_reg;
	logic [UT_W-1:0]  unit_time_count;
	logic [IRQ_W-1:0] irq_enable_reg;
	logic [IRQ_W-1:0] irq_flag_q;
	logic [IRQ_W-1:0] irq_flag_d;
	logic [POS_W-1:0] position_latch;
	logic [CAP_W-1:0] capture_timer_latch;
	logic [CAP_W-1:0] capture_period_latch;
	logic             wd_timeout_flag;
	logic             unit_timeout_flag;
	logic             acc;
	logic             wr_acc;
	logic             rd_pos;
	logic             pulse_cond;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] set_v;
	logic [IRQ_W-1:0] clr_v;
	logic [DATA_W-1:0] rdata_d;
	logic              err_d;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [ADDR_W-1:0] r);
		return a == r;
	endfunction

	function automatic logic wr(input logic en,
			input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		return en && hit(a, r);
	endfunction

	// Decoder configuration from control bits
	assign dif.src  = dec_ctl_q[SRC_HI:SRC_LO];
	assign dif.rate = dec_ctl_q[RATE_B];
	assign dif.swap = dec_ctl_q[SWAP_B];
	assign dif.gate = dec_ctl_q[GATE_B];
	assign dif.inv  = dec_ctl_q[INV_HI:INV_LO];

	qep_decoder u_dec (
		.pclk       (pclk),
		.presetn    (presetn),
		.d          (dif),
		.phase_a_in (phase_a_in),
		.phase_b_in (phase_b_in),
		.index_in   (index_in),
		.strobe_in  (strobe_in)
	);

	qep_timers #(
		.WD_W (WD_W),
		.UT_W (UT_W)
	) u_tmr (
		.pclk         (pclk),
		.presetn      (presetn),
		.wd_en        (ctl_q[WD_EN_B]),
		.unit_en      (ctl_q[UNIT_EN_B]),
		.cnt_pulse    (dif.cnt_pulse),
		.wd_period    (wd_period_reg),
		.unit_period  (unit_period_reg),
		.wd_count     (wd_count_reg),
		.unit_count   (unit_time_count),
		.wd_timeout   (wd_timeout_flag),
		.unit_timeout (unit_timeout_flag)
	);

	assign quad_clock     = dif.cnt_pulse;
	assign quad_direction = dif.cnt_dir;
	assign index_level    = dif.idx;
	assign strobe_level   = dif.stb;

	// No wait state: ready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready <= psel && !penable && !pready;
			if (psel && !penable) begin
				prdata  <= pwrite ? '0 : rdata_d;
				pslverr <= err_d;
			end else if (pready) begin
				pslverr <= 1'b0;
				prdata  <= '0;
			end
		end
	end

	assign acc    = psel && penable && pready;
	assign wr_acc = acc && pwrite;
	assign rd_pos = acc && !pwrite && hit(paddr, A_POS_CNT);

	always_comb begin
		rdata_d = '0;
		err_d   = 1'b0;
		case (paddr)
			A_DEC_CTL:  rdata_d = DATA_W'(dec_ctl_q);
			A_CTL:      rdata_d = DATA_W'(ctl_q);
			A_WD_PRD:   rdata_d = DATA_W'(wd_period_reg);
			A_WD_CNT:   rdata_d = DATA_W'(wd_count_reg);
			A_UNIT_PRD: rdata_d = DATA_W'(unit_period_reg);
			A_UNIT_CNT: rdata_d = DATA_W'(unit_time_count);
			A_IRQ_EN:   rdata_d = DATA_W'(irq_enable_reg);
			A_IRQ_FLG:  rdata_d = DATA_W'(irq_flag_q);
			A_IRQ_CLR:  rdata_d = '0;
			A_IRQ_FRC:  rdata_d = '0;
			A_POS_CNT:  rdata_d = DATA_W'(position_count);
			A_POS_LAT:  rdata_d = DATA_W'(position_latch);
			A_CTMR_LAT: rdata_d = DATA_W'(capture_timer_latch);
			A_CPRD_LAT: rdata_d = DATA_W'(capture_period_latch);
			default:    err_d   = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_ctl_q <= DEC_CTL_RST;
		end else if (wr(wr_acc, paddr, A_DEC_CTL)) begin
			dec_ctl_q <= pwdata[15:0] & DEC_CTL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q           <= CTL_RST;
			wd_period_reg   <= '0;
			unit_period_reg <= '0;
			irq_enable_reg  <= '0;
		end else begin
			if (wr(wr_acc, paddr, A_CTL)) begin
				ctl_q <= pwdata[2:0];
			end
			if (wr(wr_acc, paddr, A_WD_PRD)) begin
				wd_period_reg <= pwdata[WD_W-1:0];
			end
			if (wr(wr_acc, paddr, A_UNIT_PRD)) begin
				unit_period_reg <= pwdata[UT_W-1:0];
			end
			if (wr(wr_acc, paddr, A_IRQ_EN)) begin
				irq_enable_reg <= pwdata[IRQ_W-1:0] & EVT_MASK;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			position_latch       <= '0;
			capture_timer_latch  <= '0;
			capture_period_latch <= '0;
		end else if (ctl_q[CLM_B] && unit_timeout_flag) begin
			position_latch       <= position_count;
			capture_timer_latch  <= capture_timer;
			capture_period_latch <= capture_period;
		end else if (!ctl_q[CLM_B] && rd_pos) begin
			capture_timer_latch  <= capture_timer;
			capture_period_latch <= capture_period;
		end
	end

	always_comb begin
		ev        = ext_events & EXT_MASK;
		ev[F_PHASE]  = dif.phase_err;
		ev[F_DIRCHG] = dif.dir_chg;
		ev[F_WDOG]   = wd_timeout_flag;
		ev[F_UNIT]   = unit_timeout_flag;
	end

	assign set_v = ev | ({IRQ_W{wr(wr_acc, paddr, A_IRQ_FRC)}}
		& pwdata[IRQ_W-1:0] & EVT_MASK);
	assign clr_v = {IRQ_W{wr(wr_acc, paddr, A_IRQ_CLR)}}
		& pwdata[IRQ_W-1:0];
	assign pulse_cond = |(irq_flag_q & irq_enable_reg & EVT_MASK)
		&& !irq_flag_q[F_INT];

	// A set in the clearing cycle wins
	always_comb begin
		irq_flag_d = ((irq_flag_q & ~clr_v) | set_v) & EVT_MASK;
		irq_flag_d[F_INT] = (irq_flag_q[F_INT] & ~clr_v[F_INT])
			| pulse_cond;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_flag_q <= '0;
			irq        <= 1'b0;
		end else begin
			irq_flag_q <= irq_flag_d;
			irq        <= pulse_cond;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_oe   <= 1'b0;
			index_out  <= 1'b0;
			strobe_oe  <= 1'b0;
			strobe_out <= 1'b0;
		end else begin
			index_oe   <= dec_ctl_q[SYNC_EN_B] && !dec_ctl_q[SYNC_PIN_B];
			strobe_oe  <= dec_ctl_q[SYNC_EN_B] && dec_ctl_q[SYNC_PIN_B];
			index_out  <= dec_ctl_q[SYNC_EN_B] && !dec_ctl_q[SYNC_PIN_B]
				&& sync_pulse;
			strobe_out <= dec_ctl_q[SYNC_EN_B] && dec_ctl_q[SYNC_PIN_B]
				&& sync_pulse;
		end
	end

	property p_utl;
		@(posedge pclk) disable iff (!presetn)
		(ctl_q[CLM_B] && unit_timeout_flag)
			|=> position_latch == $past(position_count)
			&& capture_period_latch == $past(capture_period);
	endproperty
	a_utl: assert property (p_utl)
		else $error("unit time-out latch missed");

	property p_rdl;
		@(posedge pclk) disable iff (!presetn)
		(!ctl_q[CLM_B] && rd_pos)
			|=> capture_timer_latch == $past(capture_timer);
	endproperty
	a_rdl: assert property (p_rdl)
		else $error("position read latch missed");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		irq |-> !$past(irq_flag_q[F_INT]) && irq_flag_q[F_INT];
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq pulse with global flag set");

	property p_irq_once;
		@(posedge pclk) disable iff (!presetn)
		irq |=> !irq;
	endproperty
	a_irq_once: assert property (p_irq_once)
		else $error("irq wider than one cycle");

	property p_frc;
		@(posedge pclk) disable iff (!presetn)
		(wr(wr_acc, paddr, A_IRQ_FRC) && pwdata[F_WDOG])
			|=> irq_flag_q[F_WDOG];
	endproperty
	a_frc: assert property (p_frc)
		else $error("forced flag not set");

	property p_sync;
		@(posedge pclk) disable iff (!presetn)
		!dec_ctl_q[SYNC_EN_B] |=> !index_oe && !strobe_oe;
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync driven while disabled");

	property p_pin;
		@(posedge pclk) disable iff (!presetn)
		(dec_ctl_q[SYNC_EN_B] && dec_ctl_q[SYNC_PIN_B]) |=> strobe_oe
			&& !index_oe;
	endproperty
	a_pin: assert property (p_pin)
		else $error("sync on wrong pin");

	property p_rsv;
		@(posedge pclk) disable iff (!presetn)
		dec_ctl_q[INV_LO-1:0] == '0;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved control bits set");
endmodule
`default_nettype wire

/* testbench/qep_encoder_model.sv */
// Encoder sensor model driving the two phase lines
`timescale 1ns/1ps
`default_nettype none
module qep_encoder_model (
	input  wire logic pclk,    // System clock
	input  wire logic presetn, // Async reset
	input  wire logic step,    // Advance one edge
	input  wire logic fwd,     // Phase A leads when high
	output logic      phase_a, // Phase A line
	output logic      phase_b  // Phase B line
);
	logic [1:0] pos_q;
	// Gray order, so only one line moves per step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pos_q <= 2'h0;
		else if (step)
			pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
	end
	assign phase_a = ^pos_q;
	assign phase_b = pos_q[1];
endmodule
`default_nettype wire

/* testbench/qep_core_test.sv */
// Self-checking bench for the encoder interface core
`timescale 1ns/1ps
`default_nettype none
module qep_core_test import qep_pkg::*;;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, pos = 32'h0;
	logic [15:0] ctm = 16'h0, cpr = 16'h0;
	logic        pready, pslverr, err, step = 0, fwd = 1, pa, pb;
	logic        idx_in = 0, stb_in = 0, sync_pulse = 1, cnt_p, cnt_d;
	logic        idx_lv, stb_lv, idx_out, idx_oe, stb_out, stb_oe, irq;
	int          failures = 0, samples_checked = 0, qn = 0, irqn = 0;
	int          waited;
	logic [11:0] xev = 12'h000;
	logic [15:0] cv[6] = '{16'h0, 16'h0400, 16'h8000, 16'h8800,
		16'hC000, 16'h4000};
	int          en[6] = '{8, 8, 4, 2, 4, 4};
	logic        ed[6] = '{1, 0, 1, 1, 0, 0};

	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		if (cnt_p === 1'b1)
			qn++;
		if (irq === 1'b1)
			irqn++;
	end

	qep_encoder_model qep_encoder_model_i (.pclk(pclk), .presetn(presetn),
		.step(step), .fwd(fwd), .phase_a(pa), .phase_b(pb));

	qep_core qep_core_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.phase_a_in(pa), .phase_b_in(pb), .index_in(idx_in),
		.strobe_in(stb_in), .position_count(pos), .capture_timer(ctm),
		.capture_period(cpr), .ext_events(xev),
		.sync_pulse(sync_pulse), .quad_clock(cnt_p), .quad_direction(cnt_d),
		.index_level(idx_lv), .strobe_level(stb_lv), .index_out(idx_out),
		.index_oe(idx_oe), .strobe_out(stb_out), .strobe_oe(stb_oe),
		.irq(irq));

	task automatic end_sim;
		$display("failures %0d samples_checked %0d", failures,
			samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	function automatic logic [31:0] exp_mask(input logic [31:0] v,
			input logic [31:0] m);
		return v & m;
	endfunction

	// Held until pready is seen high at an edge
	task automatic apb(input logic [7:0] a, input logic w,
			input logic [31:0] d);
		int n;
		n = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) begin
			failures++;
			end_sim();
		end
	endtask

	task automatic ctl(input logic [15:0] v);
		apb(A_DEC_CTL, 1'b1, {16'h0, v});
		repeat (8) @(posedge pclk);
	endtask

	task automatic steps(input int k);
		repeat (k) begin
			step <= 1'b1;
			@(posedge pclk);
			step <= 1'b0;
			repeat (12) @(posedge pclk);
		end
	endtask

	task automatic wait_irq(input int base, input int lim);
		for (waited = 0; waited < lim && irqn == base; waited++)
			@(posedge pclk);
		if (irqn == base) begin
			failures++;
			end_sim();
		end
	endtask

	initial begin
		int          i, b, per;
		logic [31:0] d;
		logic [11:0] xv;
		i = $urandom(32'h5d283df1);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		pos <= $urandom;
		ctm <= 16'($urandom);
		cpr <= 16'($urandom);
		d = $urandom;
		apb(A_DEC_CTL, 1'b0, 32'h0);
		chk(32'h0, rd);
		apb(A_DEC_CTL, 1'b1, d);
		apb(A_DEC_CTL, 1'b0, 32'h0);
		chk(exp_mask(d, {16'h0, DEC_CTL_MASK}), rd);
		apb(8'h3C, 1'b0, 32'h0);
		chk(32'h1, {31'h0, err});
		ctl(16'h2000);
		chk(32'h6, {idx_oe, idx_out, stb_oe});
		ctl(16'h3000);
		chk(32'h6, {stb_oe, stb_out, idx_oe});
		ctl(16'h1000);
		chk(32'h0, {idx_oe, stb_oe});
		ctl(16'h0060);
		chk(32'h3, {idx_lv, stb_lv});
		ctl(16'h0240);
		chk(32'h0, {31'h0, idx_lv});
		ctl(16'h0260);
		chk(32'h1, {31'h0, idx_lv});
		// Each source code, rate and swap
		for (i = 0; i < 6; i++) begin
			ctl(cv[i]);
			b = qn;
			steps(8);
			chk(en[i], qn - b);
			if (i < 5)
				chk(ed[i], {31'h0, cnt_d});
		end
		ctl(16'h0);
		apb(A_IRQ_CLR, 1'b1, 32'hFFF);
		apb(A_WD_PRD, 1'b1, 32'h2);
		apb(A_IRQ_EN, 1'b1, 32'h10);
		apb(A_CTL, 1'b1, 32'h1);
		b = irqn;
		steps(40);
		chk(b, irqn);
		wait_irq(b, 400);
		chk(32'h1, {31'h0, waited > 100 && waited < 210});
		apb(A_IRQ_FLG, 1'b0, 32'h0);
		chk(32'h11, rd & 32'h11);
		apb(A_CTL, 1'b1, 32'h0);
		apb(A_IRQ_CLR, 1'b1, 32'hFFF);
		apb(A_IRQ_FLG, 1'b0, 32'h0);
		chk(32'h0, rd);
		per = 20 + $urandom % 40;
		apb(A_UNIT_PRD, 1'b1, per);
		apb(A_IRQ_EN, 1'b1, 32'h800);
		b = irqn;
		apb(A_CTL, 1'b1, 32'h6);
		wait_irq(b, 200);
		chk(32'h1, {31'h0, waited > per - 4 && waited < per + 8});
		apb(A_IRQ_FLG, 1'b0, 32'h0);
		chk(32'h801, rd);
		apb(A_POS_LAT, 1'b0, 32'h0);
		chk(pos, rd);
		apb(A_CTMR_LAT, 1'b0, 32'h0);
		chk({16'h0, ctm}, rd);
		apb(A_CPRD_LAT, 1'b0, 32'h0);
		chk({16'h0, cpr}, rd);
		b = irqn;
		repeat (3 * per + 10) @(posedge pclk);
		chk(b, irqn);
		apb(A_CTL, 1'b1, 32'h0);
		apb(A_IRQ_CLR, 1'b1, 32'hFFF);
		ctm <= 16'($urandom);
		apb(A_POS_CNT, 1'b0, 32'h0);
		apb(A_CTMR_LAT, 1'b0, 32'h0);
		chk({16'h0, ctm}, rd);
		apb(A_IRQ_EN, 1'b1, 32'h0);
		for (i = 1; i < 12; i++) begin
			apb(A_IRQ_FRC, 1'b1, 32'h1 << i);
			apb(A_IRQ_FLG, 1'b0, 32'h0);
			chk(32'h1 << i, rd);
			apb(A_IRQ_CLR, 1'b1, 32'hFFF);
		end
		// One-cycle pulses from the other units latch
		xv = 12'($urandom) | 12'h080;
		xev <= xv;
		@(posedge pclk);
		xev <= 12'h000;
		repeat (2) @(posedge pclk);
		apb(A_IRQ_FLG, 1'b0, 32'h0);
		chk(exp_mask({20'h0, xv}, {20'h0, EXT_MASK}), rd);
		end_sim();
	end
endmodule
`default_nettype wire
